// ---- rtl/mtype_cfg.svh ----
`ifndef MTYPE_CFG_SVH
`define MTYPE_CFG_SVH

// ============================================================
// memory type encodings
`define TYPE_STRONG_UC   3'h0
`define TYPE_WEAK_UC     3'h1
`define TYPE_COMBINING   3'h2
`define TYPE_THROUGH     3'h3
`define TYPE_WRITEBACK   3'h4
`define TYPE_PROTECT     3'h5

// ============================================================
// geometry
`define ADDR_W           32
`define LINE_BYTES       64
`define CHUNK_BYTES      8
`define LINE_SHIFT       6
`define CHUNK_SHIFT      3
`define WCB_ENTRIES      4

`endif

// ---- rtl/mtype_pkg.sv ----
package mtype_pkg;
`include "mtype_cfg.svh"

    // ============================================================
    // types
    typedef enum logic [2:0] {
        strong_uncached_type = `TYPE_STRONG_UC,
        weak_uncached_type   = `TYPE_WEAK_UC,
        combining_type       = `TYPE_COMBINING,
        through_type         = `TYPE_THROUGH,
        writeback_type       = `TYPE_WRITEBACK,
        protect_type         = `TYPE_PROTECT
    } mem_type_e;

    typedef enum logic [1:0] {
        st_idle   = 2'b00,
        st_direct = 2'b01,
        st_evict  = 2'b10
    } ctl_state_e;

    typedef struct packed {
        logic              write;
        logic [`ADDR_W-1:0] addr;
        logic [63:0]       data;
        logic [7:0]        be;
        mem_type_e         mtype;
        logic              range_combine;
    } access_s;

    typedef struct packed {
        logic cacheable;
        logic spec_ok;
        logic strong_order;
        logic read_from_cache;
        logic fill_on_read_miss;
        logic write_to_cache;
        logic write_to_mem;
        logic alloc_on_write_miss;
        logic update_or_inval;
        logic hold_modified;
        logic writeback_on_dealloc;
        logic invalidate_all;
        logic combine_ok;
        logic use_wc;
    } policy_s;

    typedef struct packed {
        logic              write;
        logic              burst;
        logic              last;
        logic [`ADDR_W-1:0] addr;
        logic [63:0]       data;
        logic [7:0]        be;
    } bus_req_s;

endpackage

// ---- rtl/type_policy.sv ----
`timescale 1ns/100ps
module type_policy (
    // access attribute
    input  wire mtype_pkg::mem_type_e mtype,
    input  wire logic                 range_combine,
    // decoded policy
    output mtype_pkg::policy_s        pol
);
    import mtype_pkg::*;

    // ============================================================
    // decode
    always_comb begin
        pol = '0;
        case (mtype)
            weak_uncached_type: begin
                if (range_combine) begin
                    pol.spec_ok = 1'b1;
                    pol.use_wc  = 1'b1;
                end else begin
                    pol.strong_order = 1'b1;
                end
            end
            combining_type: begin
                pol.spec_ok = 1'b1;
                pol.use_wc  = 1'b1;
            end
            through_type: begin
                pol.cacheable         = 1'b1;
                pol.spec_ok           = 1'b1;
                pol.read_from_cache   = 1'b1;
                pol.fill_on_read_miss = 1'b1;
                pol.write_to_cache    = 1'b1;
                pol.write_to_mem      = 1'b1;
                pol.update_or_inval   = 1'b1;
                pol.combine_ok        = 1'b1;
            end
            writeback_type: begin
                pol.cacheable            = 1'b1;
                pol.spec_ok              = 1'b1;
                pol.read_from_cache      = 1'b1;
                pol.fill_on_read_miss    = 1'b1;
                pol.write_to_cache       = 1'b1;
                pol.alloc_on_write_miss  = 1'b1;
                pol.hold_modified        = 1'b1;
                pol.writeback_on_dealloc = 1'b1;
                pol.combine_ok           = 1'b1;
            end
            protect_type: begin
                pol.cacheable         = 1'b1;
                pol.spec_ok           = 1'b1;
                pol.read_from_cache   = 1'b1;
                pol.fill_on_read_miss = 1'b1;
                pol.write_to_mem      = 1'b1;
                pol.invalidate_all    = 1'b1;
            end
            // unknown codes fall back to the safest behaviour
            default: pol.strong_order = 1'b1;
        endcase
    end

endmodule // type_policy

// ---- rtl/memory_type_write_combine.sv ----
// Functional notes
// - weak uncached acts strong unless range combines
// - combining: uncached, speculative, writes buffered
// - partial buffers drain on serializing events
// - write-through: cached reads, fills, writes through
// - write-through never allocates; valid lines updated
// - through and writeback may combine writes
// - writeback allocates on miss, holds modified data
// - modified lines written back on deallocation
// - protected: cached reads, writes invalidate everywhere
// - combine buffer separate, never snooped
// - repeated writes collapse to latest data
// - buffer built from line-sized entries
// - entries filled one at a time
// - full entry leaves as one burst
// - partial entry leaves as 8-byte writes
// - one chunk per transaction, any order
// - no ordering between entry evictions
// - strong uncached: uncached, ordered, no speculation
`timescale 1ns/100ps
`include "mtype_cfg.svh"
module memory_type_write_combine #(
    parameter int N  = `WCB_ENTRIES,
    parameter int LB = `LINE_BYTES
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 resetn,
    // core access port
    input  wire logic                 req_valid,
    input  wire mtype_pkg::access_s   req,
    output logic                      req_ready_q,
    input  wire logic                 serialize,
    output logic                      resp_valid_q,
    output logic [63:0]               resp_data_q,
    // cache command port
    output logic                      cmd_valid_q,
    output logic                      cmd_write_q,
    output logic [`ADDR_W-1:0]        cmd_addr_q,
    output mtype_pkg::policy_s        cmd_pol_q,
    // system bus
    output logic                      bus_valid_q,
    output mtype_pkg::bus_req_s       bus_req_q,
    input  wire logic                 bus_ready,
    input  wire logic [63:0]          bus_rdata
);
    import mtype_pkg::*;

    localparam int CH   = LB / `CHUNK_BYTES;
    localparam int CW   = $clog2(CH);
    localparam int IW   = (N > 1) ? $clog2(N) : 1;
    localparam int TW   = `ADDR_W - `LINE_SHIFT;
    localparam logic [CW-1:0] LAST_CHUNK = CW'(CH - 1);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // ============================================================
    // helpers
    function automatic logic [IW-1:0] first_set(input logic [N-1:0] m);
        logic [IW-1:0] r;
        r = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = IW'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [TW-1:0] line_of(input logic [`ADDR_W-1:0] a);
        return a[`ADDR_W-1:`LINE_SHIFT];
    endfunction

    // ============================================================
    // state
    ctl_state_e               state_q, state_d;
    logic [N-1:0]             valid_q, valid_d;
    logic [TW-1:0]            tag_q [N];
    logic [TW-1:0]            tag_d [N];
    logic [CH-1:0][7:0]       bv_q [N];
    logic [CH-1:0][7:0]       bv_d [N];
    logic [63:0]              data_q [N][CH];
    logic [63:0]              data_d [N][CH];
    logic                     drain_q, drain_d;
    logic                     pend_q, pend_d;
    logic                     issued_q, issued_d;
    logic [IW-1:0]            ev_idx_q, ev_idx_d;
    logic [CW-1:0]            ev_chunk_q, ev_chunk_d;
    logic                     ev_burst_q, ev_burst_d;
    access_s                  req_q, req_d;
    logic                     req_ready_d;
    logic                     resp_valid_d;
    logic [63:0]              resp_data_d;
    logic                     cmd_valid_d;
    logic                     cmd_write_d;
    logic [`ADDR_W-1:0]       cmd_addr_d;
    policy_s                  cmd_pol_d;
    logic                     bus_valid_d;
    bus_req_s                 bus_req_d;

    policy_s                  pol;
    logic                     take;
    logic                     bus_free;
    logic                     hit;
    logic [IW-1:0]            hit_idx;
    logic [IW-1:0]            idx;
    logic [CW-1:0]            wchunk;
    logic [N-1:0]             full_m;
    logic                     drain_clr;

    type_policy u_policy (
        .mtype         (req.mtype),
        .range_combine (req.range_combine),
        .pol           (pol)
    );

    assign take     = req_valid & req_ready_q;
    assign bus_free = ~bus_valid_q | bus_ready;
    assign wchunk   = req.addr[`LINE_SHIFT-1:`CHUNK_SHIFT];

    always_comb begin
        hit     = 1'b0;
        hit_idx = '0;
        for (int i = 0; i < N; i++) begin
            full_m[i] = valid_q[i] & (&bv_q[i]);
            if (valid_q[i] && tag_q[i] == line_of(req.addr)) begin
                hit     = 1'b1;
                hit_idx = IW'(i);
            end
        end
    end

    // ============================================================
    // next state
    always_comb begin
        state_d      = state_q;
        valid_d      = valid_q;
        tag_d        = tag_q;
        bv_d         = bv_q;
        data_d       = data_q;
        pend_d       = pend_q;
        issued_d     = issued_q;
        ev_idx_d     = ev_idx_q;
        ev_chunk_d   = ev_chunk_q;
        ev_burst_d   = ev_burst_q;
        req_d        = req_q;
        resp_valid_d = 1'b0;
        resp_data_d  = resp_data_q;
        cmd_valid_d  = 1'b0;
        cmd_write_d  = cmd_write_q;
        cmd_addr_d   = cmd_addr_q;
        cmd_pol_d    = cmd_pol_q;
        bus_valid_d  = bus_valid_q & ~bus_ready;
        bus_req_d    = bus_req_q;
        drain_clr    = 1'b0;
        idx          = hit ? hit_idx : first_set(~valid_q);
        case (state_q)
            st_idle: begin
                if (take) begin
                    req_d = req;
                    if (pol.use_wc && req.write) begin
                        // buffer is private: no snoop path, no cache command
                        if (!hit) begin
                            valid_d[idx] = 1'b1;
                            tag_d[idx]   = line_of(req.addr);
                            bv_d[idx]    = '0;
                        end
                        for (int b = 0; b < 8; b++) begin
                            if (req.be[b]) begin
                                data_d[idx][wchunk][8*b +: 8] = req.data[8*b +: 8];
                            end
                        end
                        bv_d[idx][wchunk] = bv_d[idx][wchunk] | req.be;
                    end else begin
                        if (pol.cacheable) begin
                            cmd_valid_d = 1'b1;
                            cmd_write_d = req.write;
                            cmd_addr_d  = req.addr;
                            cmd_pol_d   = pol;
                        end
                        if (pol.use_wc || pol.strong_order || (req.write && pol.write_to_mem)) begin
                            pend_d = 1'b1;
                        end
                    end
                end else if ((drain_q && (|valid_q)) || (&valid_q) || (|full_m)) begin
                    // full entries leave first; a younger entry may overtake an older one
                    state_d    = st_evict;
                    ev_idx_d   = (|full_m) ? first_set(full_m) : first_set(valid_q);
                    ev_chunk_d = '0;
                    ev_burst_d = |full_m;
                end else if (pend_q) begin
                    state_d  = st_direct;
                    issued_d = 1'b0;
                end
                if (drain_q && !(|valid_q)) begin
                    drain_clr = 1'b1;
                end
            end
            st_direct: begin
                // one access at a time keeps uncached traffic in program order
                if (!issued_q && bus_free) begin
                    bus_valid_d     = 1'b1;
                    bus_req_d.write = req_q.write;
                    bus_req_d.burst = 1'b0;
                    bus_req_d.last  = 1'b1;
                    bus_req_d.addr  = req_q.addr;
                    bus_req_d.data  = req_q.data;
                    bus_req_d.be    = req_q.be;
                    issued_d        = 1'b1;
                end else if (issued_q && bus_valid_q && bus_ready) begin
                    resp_valid_d = 1'b1;
                    resp_data_d  = bus_rdata;
                    pend_d       = 1'b0;
                    state_d      = st_idle;
                end
            end
            st_evict: begin
                if (bus_free) begin
                    if (ev_burst_q || (|bv_q[ev_idx_q][ev_chunk_q])) begin
                        bus_valid_d     = 1'b1;
                        bus_req_d.write = 1'b1;
                        bus_req_d.burst = ev_burst_q;
                        bus_req_d.last  = ev_burst_q ? (ev_chunk_q == LAST_CHUNK) : 1'b1;
                        bus_req_d.addr  = {tag_q[ev_idx_q], ev_chunk_q, `CHUNK_SHIFT'(0)};
                        bus_req_d.data  = data_q[ev_idx_q][ev_chunk_q];
                        bus_req_d.be    = bv_q[ev_idx_q][ev_chunk_q];
                    end
                    if (ev_chunk_q == LAST_CHUNK) begin
                        valid_d[ev_idx_q] = 1'b0;
                        bv_d[ev_idx_q]    = '0;
                        state_d           = st_idle;
                    end else begin
                        ev_chunk_d = ev_chunk_q + CW'(1);
                    end
                end
            end
            default: state_d = st_idle;
        endcase
        // a serializing event in the clearing cycle still wins
        drain_d = (drain_q & ~drain_clr) | serialize | (take & pol.strong_order);
        req_ready_d = (state_d == st_idle) & ~drain_d & ~pend_d & ~(&valid_d);
    end

    // ============================================================
    // registers
    always_ff @(posedge clock) begin
        // payload needs no reset: byte-valid bits gate every use of it
        data_q <= data_d;
        if (!resetn) begin
            state_q      <= st_idle;
            valid_q      <= '0;
            drain_q      <= 1'b0;
            pend_q       <= 1'b0;
            issued_q     <= 1'b0;
            ev_idx_q     <= '0;
            ev_chunk_q   <= '0;
            ev_burst_q   <= 1'b0;
            req_q        <= '0;
            req_ready_q  <= 1'b0;
            resp_valid_q <= 1'b0;
            resp_data_q  <= '0;
            cmd_valid_q  <= 1'b0;
            cmd_write_q  <= 1'b0;
            cmd_addr_q   <= '0;
            cmd_pol_q    <= '0;
            bus_valid_q  <= 1'b0;
            bus_req_q    <= '0;
            tag_q        <= '{default: '0};
            bv_q         <= '{default: '0};
        end else begin
            state_q      <= state_d;
            valid_q      <= valid_d;
            drain_q      <= drain_d;
            pend_q       <= pend_d;
            issued_q     <= issued_d;
            ev_idx_q     <= ev_idx_d;
            ev_chunk_q   <= ev_chunk_d;
            ev_burst_q   <= ev_burst_d;
            req_q        <= req_d;
            req_ready_q  <= req_ready_d;
            resp_valid_q <= resp_valid_d;
            resp_data_q  <= resp_data_d;
            cmd_valid_q  <= cmd_valid_d;
            cmd_write_q  <= cmd_write_d;
            cmd_addr_q   <= cmd_addr_d;
            cmd_pol_q    <= cmd_pol_d;
            bus_valid_q  <= bus_valid_d;
            bus_req_q    <= bus_req_d;
            tag_q        <= tag_d;
            bv_q         <= bv_d;
        end
    end

    // ============================================================
    // checks
    logic [CW-1:0] beat_q;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            beat_q <= '0;
        end else if (bus_valid_q && bus_ready && bus_req_q.burst) begin
            beat_q <= bus_req_q.last ? '0 : beat_q + CW'(1);
        end
    end

    sequence s_uc_take;
        take && pol.strong_order;
    endsequence
    sequence s_uc_wait;
        pend_q && drain_q && !cmd_valid_q;
    endsequence

    a_burst_full: assert property (bus_valid_q && bus_req_q.burst |-> &bus_req_q.be)
        else $error("burst beat without all bytes valid");
    a_burst_len: assert property (bus_valid_q && bus_req_q.burst && bus_req_q.last |-> beat_q == LAST_CHUNK)
        else $error("burst did not carry a whole line");
    a_partial_chunk: assert property (bus_valid_q && !bus_req_q.burst
        |-> bus_req_q.last && bus_req_q.be != 8'h00 && bus_req_q.addr[2:0] == 3'h0)
        else $error("partial write not a single aligned chunk");
    a_uc_ordered: assert property (s_uc_take |=> s_uc_wait)
        else $error("strong uncached access not held for ordered issue");
    a_direct_stall: assert property (state_q == st_direct |-> !req_ready_q)
        else $error("new access accepted while uncached access in flight");
    a_serial_drain: assert property (serialize |=> drain_q ##0 !req_ready_q)
        else $error("serializing event did not start a drain");
    a_wt_policy: assert property (cmd_valid_q && cmd_pol_q.update_or_inval
        |-> cmd_pol_q.write_to_mem && !cmd_pol_q.alloc_on_write_miss)
        else $error("write-through policy allocates or skips memory");
    a_wb_policy: assert property (cmd_valid_q && cmd_pol_q.hold_modified
        |-> cmd_pol_q.alloc_on_write_miss && !cmd_pol_q.write_to_mem && cmd_pol_q.writeback_on_dealloc)
        else $error("write-back policy inconsistent");
    a_wp_write: assert property (take && req.write && req.mtype == protect_type
        |=> pend_q && cmd_pol_q.invalidate_all && !cmd_pol_q.write_to_cache)
        else $error("protected write not sent to bus with invalidate");
    a_wc_private: assert property (take && pol.use_wc && req.write |=> !cmd_valid_q && !pend_q && |valid_q)
        else $error("combining write leaked out of the buffer");

endmodule // memory_type_write_combine

// ---- tb/bus_model.sv ----
`timescale 1ns/100ps
// ============================================================
// system bus responder, prompt or stalling
module bus_model (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                resetn,
    // pace select
    input  wire logic                slow,
    // system bus
    input  wire logic                bus_valid_q,
    input  wire mtype_pkg::bus_req_s bus_req_q,
    output logic                     bus_ready,
    output logic [63:0]              bus_rdata
);
    import mtype_pkg::*;
    logic [7:0] cnt_q;
    always_ff @(posedge clock) begin
        cnt_q     <= resetn ? cnt_q + 8'h01 : 8'h00;
        bus_ready <= resetn && (!slow || cnt_q[1:0] == 2'h3);
    end
    // outside acceptance the data churns, so a late or early sample is caught
    assign bus_rdata = bus_ready ? {bus_req_q.addr, ~bus_req_q.addr} : {8{cnt_q}};
endmodule // bus_model

// ---- tb/memory_type_write_combine_bench.sv ----
`timescale 1ns/100ps
module memory_type_write_combine_bench;
    import mtype_pkg::*;
    // ============================================================
    // signals
    logic        clock, resetn, req_valid, serialize, slow, bus_ready, bus_valid_q;
    logic        req_ready_q, resp_valid_q, cmd_valid_q, cmd_write_q;
    logic [63:0] resp_data_q, bus_rdata;
    logic [31:0] cmd_addr_q, lfsr_q, open_line;
    logic [63:0] line_v;
    logic [511:0] line_b;
    access_s     req;
    policy_s     cmd_pol_q;
    bus_req_s    bus_req_q, eb;
    logic [64:0] er;
    bus_req_s    exp_beat[$];
    logic [64:0] exp_resp[$];
    logic [40:0] exp_cmd[$];
    int          num_errors, compares, cycles;

    memory_type_write_combine i_memory_type_write_combine (.clock(clock), .resetn(resetn),
        .req_valid(req_valid), .req(req), .req_ready_q(req_ready_q), .serialize(serialize),
        .resp_valid_q(resp_valid_q), .resp_data_q(resp_data_q), .cmd_valid_q(cmd_valid_q),
        .cmd_write_q(cmd_write_q), .cmd_addr_q(cmd_addr_q), .cmd_pol_q(cmd_pol_q),
        .bus_valid_q(bus_valid_q), .bus_req_q(bus_req_q), .bus_ready(bus_ready), .bus_rdata(bus_rdata));
    bus_model i_bus_model (.clock(clock), .resetn(resetn), .slow(slow), .bus_valid_q(bus_valid_q),
        .bus_req_q(bus_req_q), .bus_ready(bus_ready), .bus_rdata(bus_rdata));

    initial begin
        clock = 0;
        forever #2.5 clock = ~clock;
    end

    // ============================================================
    // checking
    task automatic report(logic [127:0] got, logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // bytes without a strobe carry no meaning on the bus
    function automatic bus_req_s msk(bus_req_s b);
        for (int i = 0; i < 8; i++) if (!b.write || !b.be[i]) b.data[8*i+:8] = 8'h00;
        return b;
    endfunction
    task automatic cmp_beat(bus_req_s got, bus_req_s exp);
        report(msk(got), msk(exp));
    endtask
    task automatic cmp_resp(logic [63:0] got, logic [63:0] exp);
        report(got, exp);
    endtask
    task automatic cmp_cmd(logic [40:0] got, logic [40:0] exp);
        report(got, exp);
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            conclude();
        end
        if (resetn && bus_valid_q && bus_ready) begin
            eb = exp_beat.size() ? exp_beat.pop_front() : 'x;
            cmp_beat(bus_req_q, eb);
        end
        if (resp_valid_q) begin
            er = exp_resp.size() ? exp_resp.pop_front() : 'x;
            if (er[64] !== 1'b0) cmp_resp(resp_data_q, er[63:0]);
        end
        if (cmd_valid_q) cmp_cmd({cmd_write_q, cmd_addr_q, cmd_pol_q.read_from_cache,
            cmd_pol_q.fill_on_read_miss, cmd_pol_q.write_to_mem, cmd_pol_q.alloc_on_write_miss,
            cmd_pol_q.hold_modified, cmd_pol_q.writeback_on_dealloc, cmd_pol_q.invalidate_all,
            cmd_pol_q.strong_order}, exp_cmd.size() ? exp_cmd.pop_front() : 'x);
    end

    // ============================================================
    // reference model
    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], ^(lfsr_q & 32'h80200003)};
        return lfsr_q;
    endfunction
    function automatic logic [7:0] flags(mem_type_e t);
        if (t == through_type) return 8'hE0;
        if (t == writeback_type) return 8'hDC;
        return 8'hE2;
    endfunction
    task automatic evict();
        logic [7:0] be;
        for (int c = 0; c < 8; c++) begin
            be = line_v[c*8+:8];
            if (be != 8'h00) exp_beat.push_back('{1'b1, &line_v, !(&line_v) || c == 7,
                {open_line[31:6], c[2:0], 3'h0}, line_b[c*64+:64], be});
        end
        line_v = '0;
        line_b = '0;
    endtask
    task automatic direct(logic w, logic [31:0] a, logic [63:0] d, logic [7:0] be);
        exp_beat.push_back('{w, 1'b0, 1'b1, a, d, be});
        exp_resp.push_back({!w, a, ~a});
    endtask
    task automatic access(logic w, logic [31:0] a, logic [63:0] d, logic [7:0] be, mem_type_e t, logic rc);
        int  n;
        logic comb;
        comb = t == combining_type || (t == weak_uncached_type && rc);
        req = '{w, a, d, be, t, rc};
        req_valid = 1;
        n = 0;
        while (req_ready_q !== 1'b1 && n < 1000) begin
            @(posedge clock) #1;
            n++;
        end
        @(posedge clock) #1;
        if (comb && w) begin
            open_line = a;
            for (int i = 0; i < 8; i++) if (be[i]) begin
                line_b[(a[5:3]*8+i)*8+:8] = d[8*i+:8];
                line_v[a[5:3]*8+i] = 1'b1;
            end
            if (&line_v) evict();
        end else if (t inside {through_type, writeback_type, protect_type}) begin
            exp_cmd.push_back({w, a, flags(t)});
            if (w && t != writeback_type) direct(w, a, d, be);
        end else begin
            // a strong-order uncached access serialises, so pending combined data goes first
            if (!comb) evict();
            direct(w, a, d, be);
        end
    endtask
    task automatic fence();
        req_valid = 0;
        serialize = 1;
        @(posedge clock) #1;
        serialize = 0;
        evict();
    endtask
    task automatic settle(string name);
        int n;
        req_valid = 0;
        n = 0;
        while (exp_beat.size() + exp_resp.size() + exp_cmd.size() > 0 && n < 2000) begin
            @(posedge clock) #1;
            n++;
        end
        repeat (4) @(posedge clock);
        #1;
        report(exp_beat.size() + exp_resp.size() + exp_cmd.size(), 0);
        $display("test %s done", name);
    endtask

    // ============================================================
    // scenarios
    initial begin
        logic [31:0] r;
        mem_type_e   tl[3];
        tl = '{through_type, writeback_type, protect_type};
        {req_valid, serialize, slow, resetn, req, line_v, line_b, open_line} = '0;
        {num_errors, compares, cycles} = '0;
        lfsr_q = 32'h71bc;
        repeat (3) @(posedge clock);
        #1 resetn = 1;
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            access(1, 32'h1000 + 32'(r[1:0] % 2'h3) * 32'h8, {r, ~r}, r[15:8], combining_type, 0);
        end
        fence();
        settle("collapse");
        slow = 1;
        r = rnd();
        access(1, 32'h1058, {~r, r}, 8'hFF, combining_type, 0);
        for (int c = 0; c < 8; c++) begin
            r = rnd();
            access(1, 32'h1040 + c * 8, {r, r}, 8'hFF, c[0] ? weak_uncached_type : combining_type, 1);
        end
        settle("burst");
        for (int c = 1; c < 7; c += 4) begin
            r = rnd();
            access(1, 32'h2000 + c * 8, {r, ~r}, r[7:0] | 8'h01, combining_type, 0);
        end
        access(1, 32'h3008, {2{r}}, 8'h0F, strong_uncached_type, 0);
        access(0, 32'h3010, 64'h0, 8'hFF, weak_uncached_type, 0);
        settle("ordered");
        slow = 0;
        for (int k = 0; k < 6; k++) begin
            r = rnd();
            access(k[0], 32'h4000 + k * 64, {r, r}, 8'hFF, tl[k/2], 0);
        end
        access(0, 32'h5000, 64'h0, 8'hFF, combining_type, 0);
        access(0, 32'h5008, 64'h0, 8'hFF, mem_type_e'(3'h6), 0);
        settle("types");
        conclude();
    end
endmodule // memory_type_write_combine_bench
